/* File: common/state_clock_qualifier_defines.svh */
// Register offsets, field positions and reset values of the state clock qualifier.
`ifndef STATE_CLOCK_QUALIFIER_DEFINES_SVH
`define STATE_CLOCK_QUALIFIER_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define SCQ_CTRL           8'h00
`define SCQ_STATUS         8'h04
`define SCQ_PRETRIGGER_WORD_COUNT        8'h08
`define SCQ_SHOW_MASK_LO   8'h0c
`define SCQ_SHOW_MASK_HI   8'h10
`define SCQ_READ_INDEX     8'h14
`define SCQ_READ_DATA_LO   8'h18
`define SCQ_READ_DATA_HI   8'h1c
`define SCQ_QUAL_BASE0     8'h20
`define SCQ_QUAL_BASE1     8'h40

// ==========================================================================
// Offsets inside one qualification block, address bits [4:2]
`define SCQ_QF_VAL_LO      3'h0
`define SCQ_QF_VAL_HI      3'h1
`define SCQ_QF_CARE_LO     3'h2
`define SCQ_QF_CARE_HI     3'h3
`define SCQ_QF_AUX         3'h4

// ==========================================================================
// Control register fields
`define SCQ_CTRL_FALL_LSB  0
`define SCQ_CTRL_FOLLOW    3
`define SCQ_CTRL_QEN_LSB   4
`define SCQ_CTRL_LINK      6
`define SCQ_CTRL_COLLECT   8

// Qualification auxiliary register fields.
`define SCQ_AUX_QVAL_LSB   0
`define SCQ_AUX_QCARE_LSB  8
`define SCQ_AUX_EXT        16

// ==========================================================================
// Reset values and bus answers
`define SCQ_CTRL_RESET     7'h00
`define SCQ_SHOW_RESET     48'hffff_ffff_ffff
`define SCQ_RESP_OKAY      2'h0
`define SCQ_RESP_SLVERR    2'h2

`endif

/* File: common/state_clock_qualifier_pkg.sv */
// Types shared by the state clock qualifier.
`default_nettype none
package state_clock_qualifier_pkg;

  // Capture states, Gray coded along idle, pretrigger, posttrigger, done.
  typedef enum logic [1:0] {
    CAP_IDLE = 2'b00,
    CAP_PRE  = 2'b01,
    CAP_POST = 2'b11,
    CAP_DONE = 2'b10
  } capture_state_t;

endpackage
`default_nettype wire

/* File: rtl/state_clock_qualifier.sv */
// State analyser sampling front end: clock edges, qualification and pretrigger capture.
//
// Function
// - Each probe clock has its own edge.
// - B and C clocks may follow A.
// - Two qualification conditions are OR'ed together.
// - Both conditions stay off until enabled.
// - Condition word: 48 data, six qualifiers, external.
// - Qualifiers match low/high/either; external high/either.
// - Qualifier order: A pair, B pair, C pair.
// - External bit qualifies; link bit couples analysers.
// - Data word: A top, B from bit 16, C from bit 0.
// - Masked display bits read back as blank.
// - Keep the programmed count of pretrigger words.
// - Reduced variant drops the whole B probe.
// - External input active high, low inhibits.
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`include "state_clock_qualifier_defines.svh"
`default_nettype none

module state_clock_qualifier
  import state_clock_qualifier_pkg::*;
#(
  parameter int DEPTH       = 1024,
  parameter bit HAS_B_PROBE = 1'b1
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        probe_clk_a,
  input  wire logic        probe_clk_b,
  input  wire logic        probe_clk_c,
  input  wire logic [15:0] probe_data_a,
  input  wire logic [15:0] probe_data_b,
  input  wire logic [15:0] probe_data_c,
  input  wire logic [2:0]  probe_qualifier_first,
  input  wire logic [2:0]  probe_qualifier_second,
  input  wire logic        external_qualify_input,
  input  wire logic        trigger_in,
  output logic             sample_valid,
  output logic [47:0]      sample_word,
  output logic             link_out
);

  localparam int AW = $clog2(DEPTH);

  // ==========================================================================
  // Register state
  logic [2:0]        clk_fall;
  logic              follow_a;
  logic [1:0]        qual_en;
  logic              link_en;
  logic [AW-1:0]     pretrigger_word_count;
  logic [47:0]       show_mask;
  logic [AW-1:0]     read_index;
  logic [47:0]       qual_val  [2];
  logic [47:0]       qual_care [2];
  logic [5:0]        grp_val   [2];
  logic [5:0]        grp_care  [2];
  logic [1:0]        ext_use;
  capture_state_t    state;
  logic [AW-1:0]     wptr;
  logic [AW-1:0]     fill;
  logic [AW-1:0]     post_left;
  logic [AW-1:0]     trig_ptr;
  logic [47:0]       mem [DEPTH];
  logic [2:0]        clk_prev;
  logic [15:0]       hold_b;
  logic [15:0]       hold_c;

  // Byte-lane merge so partial writes leave the other lanes intact.
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // Bus write decode
  // Address and data are taken together so the slave never holds half a write.
  wire        wr_fire   = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire [7:0]  waddr     = {s_axi_awaddr[7:2], 2'b00};
  wire        wr_qual   = (waddr[7:5] == 3'b001) || (waddr[7:5] == 3'b010);
  wire        wr_qk     = waddr[6];
  wire [2:0]  wr_qf     = waddr[4:2];
  wire        wr_ctrl   = wr_fire && waddr == `SCQ_CTRL;
  wire        wr_pre    = wr_fire && waddr == `SCQ_PRETRIGGER_WORD_COUNT;
  wire        wr_mlo    = wr_fire && waddr == `SCQ_SHOW_MASK_LO;
  wire        wr_mhi    = wr_fire && waddr == `SCQ_SHOW_MASK_HI;
  wire        wr_idx    = wr_fire && waddr == `SCQ_READ_INDEX;
  wire        wr_q      = wr_fire && wr_qual && wr_qf <= `SCQ_QF_AUX;
  wire        wr_known  = wr_ctrl || wr_pre || wr_mlo || wr_mhi || wr_idx || wr_q
                          || (wr_fire && (waddr == `SCQ_STATUS || waddr == `SCQ_READ_DATA_LO
                          || waddr == `SCQ_READ_DATA_HI));
  wire [31:0] ctrl_word = {25'h0, link_en, qual_en, follow_a, clk_fall};
  wire [31:0] ctrl_new  = merge(ctrl_word, s_axi_wdata, s_axi_wstrb);
  wire        collect   = wr_ctrl && s_axi_wstrb[1] && s_axi_wdata[`SCQ_CTRL_COLLECT];
  wire [31:0] pre_new   = merge(32'(pretrigger_word_count), s_axi_wdata, s_axi_wstrb);
  wire [31:0] mlo_new   = merge(show_mask[31:0], s_axi_wdata, s_axi_wstrb);
  wire [31:0] mhi_new   = merge({16'h0, show_mask[47:32]}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] idx_new   = merge(32'(read_index), s_axi_wdata, s_axi_wstrb);

  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;

  // Control registers; qualification conditions come up disabled.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      {link_en, qual_en, follow_a, clk_fall} <= `SCQ_CTRL_RESET;
      pretrigger_word_count <= '0;
      show_mask             <= `SCQ_SHOW_RESET;
      read_index            <= '0;
    end else begin
      if (wr_ctrl) begin
        {link_en, qual_en, follow_a, clk_fall} <= ctrl_new[6:0];
      end
      if (wr_pre) begin
        pretrigger_word_count <= pre_new[AW-1:0];
      end
      if (wr_mlo) begin
        show_mask[31:0] <= mlo_new;
      end
      if (wr_mhi) begin
        show_mask[47:32] <= mhi_new[15:0];
      end
      if (wr_idx) begin
        read_index <= idx_new[AW-1:0];
      end
    end
  end

  // Two qualification words, each 48 data, six group and one external bit.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < 2; k++) begin
        qual_val[k]  <= '0;
        qual_care[k] <= '0;
        grp_val[k]   <= '0;
        grp_care[k]  <= '0;
      end
      ext_use <= '0;
    end else if (wr_q) begin
      unique case (wr_qf)
        `SCQ_QF_VAL_LO:  qual_val[wr_qk][31:0]   <= merge(qual_val[wr_qk][31:0],
                                                           s_axi_wdata, s_axi_wstrb);
        `SCQ_QF_VAL_HI:  qual_val[wr_qk][47:32]  <= 16'(merge({16'h0, qual_val[wr_qk][47:32]},
                                                           s_axi_wdata, s_axi_wstrb));
        `SCQ_QF_CARE_LO: qual_care[wr_qk][31:0]  <= merge(qual_care[wr_qk][31:0],
                                                           s_axi_wdata, s_axi_wstrb);
        `SCQ_QF_CARE_HI: qual_care[wr_qk][47:32] <= 16'(merge({16'h0, qual_care[wr_qk][47:32]},
                                                           s_axi_wdata, s_axi_wstrb));
        default: begin
          if (s_axi_wstrb[0]) grp_val[wr_qk]  <= s_axi_wdata[`SCQ_AUX_QVAL_LSB +: 6];
          if (s_axi_wstrb[1]) grp_care[wr_qk] <= s_axi_wdata[`SCQ_AUX_QCARE_LSB +: 6];
          if (s_axi_wstrb[2]) ext_use[wr_qk]  <= s_axi_wdata[`SCQ_AUX_EXT];
        end
      endcase
    end
  end

  // Write response follows the accepted write; unmapped addresses answer SLVERR.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SCQ_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? `SCQ_RESP_OKAY : `SCQ_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Probe clock edges
  // Probe inputs are synchronous to core_clk, so a previous-value compare finds edges.
  wire [2:0] rise      = ~clk_prev & {probe_clk_c, probe_clk_b, probe_clk_a};
  wire [2:0] fall      = clk_prev & ~{probe_clk_c, probe_clk_b, probe_clk_a};
  wire       edge_a    = clk_fall[0] ? fall[0] : rise[0];
  wire       own_b     = clk_fall[1] ? fall[1] : rise[1];
  wire       own_c     = clk_fall[2] ? fall[2] : rise[2];
  wire       edge_b    = HAS_B_PROBE && (follow_a ? edge_a : own_b);
  wire       edge_c    = follow_a ? edge_a : own_c;
  wire [15:0] now_b    = !HAS_B_PROBE ? 16'h0000 : (edge_b ? probe_data_b : hold_b);
  wire [15:0] now_c    = edge_c ? probe_data_c : hold_c;
  wire [47:0] word     = {probe_data_a, now_b, now_c};
  wire [5:0]  group    = {probe_qualifier_first[0], probe_qualifier_second[0],
                          probe_qualifier_first[1], probe_qualifier_second[1],
                          probe_qualifier_first[2], probe_qualifier_second[2]};
  wire [47:0] b_keep   = HAS_B_PROBE ? 48'hffff_ffff_ffff : 48'hffff_0000_ffff;
  wire [5:0]  g_keep   = HAS_B_PROBE ? 6'h3f : 6'h33;

  // Each condition compares only its cared-for bits; B bits drop out on the reduced part.
  logic [1:0] match;
  for (genvar k = 0; k < 2; k++) begin : g_cond
    assign match[k] = (((word ^ qual_val[k]) & qual_care[k] & b_keep) == 48'h0)
                      && (((group ^ grp_val[k]) & grp_care[k] & g_keep) == 6'h0)
                      && (!ext_use[k] || external_qualify_input);
  end

  wire any_match = |(qual_en & match);
  wire store     = edge_a && ((qual_en == 2'b00) || any_match);

  // Multiphase hold: B and C data are latched on their own edges and stored on A.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clk_prev <= '0;
      hold_b   <= '0;
      hold_c   <= '0;
    end else begin
      clk_prev <= {probe_clk_c, probe_clk_b, probe_clk_a};
      if (edge_b) hold_b <= probe_data_b;
      if (edge_c) hold_c <= probe_data_c;
    end
  end

  // Sample strobe and link line toward the trigger logic and companion analysers.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sample_valid <= 1'b0;
      sample_word  <= '0;
      link_out     <= 1'b0;
    end else begin
      sample_valid <= store;
      link_out     <= link_en && store;
      if (store) sample_word <= word;
    end
  end

  // ==========================================================================
  // Capture with pretrigger history
  // A trigger is only honoured once the pretrigger history is full, so the count is exact.
  wire           trig_ok = store && trigger_in && fill == pretrigger_word_count;
  wire [AW-1:0]  post_n  = AW'(DEPTH - 1) - pretrigger_word_count;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state     <= CAP_IDLE;
      wptr      <= '0;
      fill      <= '0;
      post_left <= '0;
      trig_ptr  <= '0;
    end else if (collect) begin
      state <= CAP_PRE;
      wptr  <= '0;
      fill  <= '0;
    end else begin
      unique case (state)
        CAP_PRE: if (store) begin
          wptr <= wptr + 1'b1;
          if (trig_ok) begin
            trig_ptr  <= wptr;
            post_left <= post_n;
            state     <= (post_n == '0) ? CAP_DONE : CAP_POST;
          end else if (fill != pretrigger_word_count) begin
            fill <= fill + 1'b1;
          end
        end
        CAP_POST: if (store) begin
          wptr      <= wptr + 1'b1;
          post_left <= post_left - 1'b1;
          if (post_left == AW'(1)) state <= CAP_DONE;
        end
        CAP_IDLE, CAP_DONE: ;
      endcase
    end
  end

  // The sample memory carries no reset; reading an index not yet written returns an unknown word.
  always_ff @(posedge core_clk) begin
    if (store && (state == CAP_PRE || state == CAP_POST) && !collect) begin
      mem[wptr] <= word;
    end
  end

  // ==========================================================================
  // Bus read decode
  // Index 0 is the oldest pretrigger word; the trigger word sits at the pretrigger count.
  wire [AW-1:0] rd_ptr   = trig_ptr - pretrigger_word_count + read_index;
  wire [47:0]   shown    = mem[rd_ptr] & show_mask;
  wire [7:0]    raddr    = {s_axi_araddr[7:2], 2'b00};
  wire          rd_fire  = s_axi_arvalid && !s_axi_rvalid;
  wire          rd_qual  = ((raddr[7:5] == 3'b001) || (raddr[7:5] == 3'b010))
                           && raddr[4:2] <= `SCQ_QF_AUX;
  wire          rd_qk    = raddr[6];
  wire [31:0]   rd_qword = (raddr[4:2] == `SCQ_QF_VAL_LO)  ? qual_val[rd_qk][31:0] :
                           (raddr[4:2] == `SCQ_QF_VAL_HI)  ? {16'h0, qual_val[rd_qk][47:32]} :
                           (raddr[4:2] == `SCQ_QF_CARE_LO) ? qual_care[rd_qk][31:0] :
                           (raddr[4:2] == `SCQ_QF_CARE_HI) ? {16'h0, qual_care[rd_qk][47:32]} :
                           {15'h0, ext_use[rd_qk], 2'h0, grp_care[rd_qk], 2'h0, grp_val[rd_qk]};
  wire [31:0]   status   = {16'(trig_ptr), 14'h0, state};
  wire          rd_known = rd_qual || raddr <= `SCQ_READ_DATA_HI;
  wire [31:0]   rd_word  = (raddr == `SCQ_CTRL)         ? ctrl_word :
                           (raddr == `SCQ_STATUS)       ? status :
                           (raddr == `SCQ_PRETRIGGER_WORD_COUNT)      ? 32'(pretrigger_word_count) :
                           (raddr == `SCQ_SHOW_MASK_LO) ? show_mask[31:0] :
                           (raddr == `SCQ_SHOW_MASK_HI) ? {16'h0, show_mask[47:32]} :
                           (raddr == `SCQ_READ_INDEX)   ? 32'(read_index) :
                           (raddr == `SCQ_READ_DATA_LO) ? shown[31:0] :
                           (raddr == `SCQ_READ_DATA_HI) ? {16'h0, shown[47:32]} :
                           rd_qual ? rd_qword : 32'h0;

  assign s_axi_arready = !s_axi_rvalid;

  // Read data is registered one cycle after the address is taken.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `SCQ_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_known ? `SCQ_RESP_OKAY : `SCQ_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // state_clock_qualifier

`default_nettype wire

/* File: verif/state_clock_qualifier_monitor.sv */
// Checker of store timing, sample word layout and bus answers of the qualifier.
`default_nettype none
module state_clock_qualifier_monitor (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        probe_clk_a,
  input wire logic [15:0] probe_data_a,
  input wire logic [15:0] probe_data_b,
  input wire logic [15:0] probe_data_c,
  input wire logic        sample_valid,
  input wire logic [47:0] sample_word,
  input wire logic        link_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [6:0] ctrl;
  wire        wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire        plain = (ctrl[5:4] == 2'h0);
  // Shadow of the control word, so edge rules can be judged without peeking inside.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) ctrl <= 7'h00;
    else if (wr_hs && s_axi_awaddr == 8'h00) ctrl <= s_axi_wdata[6:0];
  end
  a_rise_stores: assert property ($rose(probe_clk_a) && !ctrl[0] && plain |=> sample_valid)
    else $error("rising edge not stored");
  a_fall_stores: assert property ($fell(probe_clk_a) && ctrl[0] && plain |=> sample_valid)
    else $error("falling edge not stored");
  a_no_edge_idle: assert property (!$changed(probe_clk_a) |=> !sample_valid)
    else $error("store without an edge");
  a_valid_pulse: assert property (sample_valid |=> !sample_valid)
    else $error("store pulse too long");
  a_word_a_top: assert property (sample_valid |-> sample_word[47:32] == $past(probe_data_a))
    else $error("A data misplaced");
  a_word_bc_follow: assert property (sample_valid && ctrl[3]
    |-> sample_word[31:0] == $past({probe_data_b, probe_data_c}))
    else $error("B or C data misplaced");
  a_link_pulse: assert property (sample_valid |-> link_out == ctrl[6])
    else $error("link output wrong");
  a_link_only: assert property (link_out |-> sample_valid)
    else $error("link without a store");
  a_write_answer: assert property (wr_hs |=> s_axi_bvalid)
    else $error("write not answered");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
endmodule // state_clock_qualifier_monitor
bind state_clock_qualifier state_clock_qualifier_monitor u_monitor (.core_clk, .nrst,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .probe_clk_a, .probe_data_a, .probe_data_b,
  .probe_data_c, .sample_valid, .sample_word, .link_out);
`default_nettype wire

/* File: verif/probe_side_model.sv */
// Model of the probed system: clocks, data, qualifiers and the external line.
`default_nettype none
module probe_side_model (
  input wire logic   core_clk,
  output logic       probe_clk_a,
  output logic       probe_clk_b,
  output logic       probe_clk_c,
  output logic [15:0] probe_data_a,
  output logic [15:0] probe_data_b,
  output logic [15:0] probe_data_c,
  output logic [2:0] probe_qualifier_first,
  output logic [2:0] probe_qualifier_second,
  output logic       external_qualify_input
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clocks rest low between strobes; the system under test clocks only when it has data.
  initial begin
    {probe_clk_a, probe_clk_b, probe_clk_c} = 3'h0;
    {probe_data_a, probe_data_b, probe_data_c} = 48'h0;
    {probe_qualifier_first, probe_qualifier_second, external_qualify_input} = 7'h00;
  end
  // One full probe clock period, data stable across both edges.
  task strobe(input logic [47:0] d, input logic [2:0] qf, qs, input logic e);
    {probe_data_a, probe_data_b, probe_data_c} <= d;
    {probe_qualifier_first, probe_qualifier_second, external_qualify_input} <= {qf, qs, e};
    repeat (2) @(posedge core_clk);
    {probe_clk_a, probe_clk_b, probe_clk_c} <= 3'h7;
    repeat (3) @(posedge core_clk);
    {probe_clk_a, probe_clk_b, probe_clk_c} <= 3'h0;
    repeat (3) @(posedge core_clk);
    // Hold time over: lines move on, so a late sample would show a wrong word.
    {probe_data_a, probe_data_b, probe_data_c} <= ~d;
    {probe_qualifier_first, probe_qualifier_second, external_qualify_input} <= ~{qf, qs, e};
    @(posedge core_clk);
  endtask
endmodule // probe_side_model
`default_nettype wire

/* File: verif/state_clock_qualifier_tb_top.sv */
// Self-checking bench of the state clock qualifier.
`include "state_clock_qualifier_defines.svh"
`default_nettype none
module state_clock_qualifier_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, nrst = 1'b0, trigger_in = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic probe_clk_a, probe_clk_b, probe_clk_c, external_qualify_input;
  logic [15:0] probe_data_a, probe_data_b, probe_data_c;
  logic [2:0] probe_qualifier_first, probe_qualifier_second;
  logic sample_valid, link_out;
  logic [47:0] sample_word;
  int bad_count = 0, total_checks = 0;
  logic [47:0] exp_word[$];
  logic [33:0] exp_rd[$];
  logic [1:0] exp_wr[$];
  logic [31:0] lfsr = 32'hbf32;
  logic [47:0] d;

  // A short sample memory keeps the capture run brief.
  state_clock_qualifier #(.DEPTH(16)) u_dut (.core_clk, .nrst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .probe_clk_a, .probe_clk_b, .probe_clk_c, .probe_data_a,
    .probe_data_b, .probe_data_c, .probe_qualifier_first, .probe_qualifier_second,
    .external_qualify_input, .trigger_in, .sample_valid, .sample_word, .link_out);
  probe_side_model u_probe (.core_clk, .probe_clk_a, .probe_clk_b, .probe_clk_c,
    .probe_data_a, .probe_data_b, .probe_data_c, .probe_qualifier_first,
    .probe_qualifier_second, .external_qualify_input);

  always #4 core_clk = ~core_clk;

  // ==========================================================================
  // Comparison, verdict and random source
  task check(input logic [63:0] seen, input logic [63:0] want);
    total_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask
  task summarize;
    $display("Comparisons %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [47:0] rnd48();
    logic [31:0] hi;
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    hi = lfsr;
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return {hi[15:0], lfsr};
  endfunction

  // ==========================================================================
  // Bus master; each wait is bounded so a dead slave cannot hang the run
  task axi_write(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    bit aw, w;
    int n;
    aw = 0; w = 0; n = 0;
    exp_wr.push_back(r);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    while (!(aw && w)) begin
      @(posedge core_clk);
      if (!aw && s_axi_awready) begin aw = 1; s_axi_awvalid <= 0; end
      if (!w && s_axi_wready) begin w = 1; s_axi_wvalid <= 0; end
      if (++n > 200) begin bad_count++; summarize(); end
    end
    s_axi_bready <= 1;
    do begin
      @(posedge core_clk);
      if (++n > 400) begin bad_count++; summarize(); end
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
  endtask
  task axi_read(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    exp_rd.push_back({`SCQ_RESP_OKAY, v});
    s_axi_araddr <= a; s_axi_arvalid <= 1;
    do begin
      @(posedge core_clk);
      if (++n > 200) begin bad_count++; summarize(); end
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0; s_axi_rready <= 1;
    do begin
      @(posedge core_clk);
      if (++n > 400) begin bad_count++; summarize(); end
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
  endtask
  // Notes the expected store, then lets the probe model clock one word in.
  task hit(input logic [47:0] v, input logic [2:0] qf, qs, input logic e, input bit st);
    if (st) exp_word.push_back(v);
    u_probe.strobe(v, qf, qs, e);
  endtask

  // Result watcher: each answer or store takes the oldest note of its kind.
  always @(posedge core_clk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) check(s_axi_bresp, exp_wr.pop_front());
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      check({s_axi_rresp, s_axi_rdata}, exp_rd.pop_front());
    if (sample_valid === 1'b1) begin
      if (exp_word.size() == 0) check(1, 0);
      else check(sample_word, exp_word.pop_front());
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1;
    @(posedge core_clk);
    axi_read(`SCQ_CTRL, 32'h0);
    axi_read(`SCQ_SHOW_MASK_LO, 32'hffff_ffff);
    axi_read(`SCQ_SHOW_MASK_HI, 32'h0000_ffff);
    axi_write(8'hf0, 32'h1, `SCQ_RESP_SLVERR);
    axi_write(`SCQ_PRETRIGGER_WORD_COUNT, 32'h2, `SCQ_RESP_OKAY);
    // Conditions off after reset: every rising edge stores, B and C follow A.
    axi_write(`SCQ_CTRL, 32'h108, `SCQ_RESP_OKAY);
    for (int i = 0; i < 3; i++) hit(rnd48(), 3'h0, 3'h0, 1'b0, 1);
    // Falling edge with the link export on.
    axi_write(`SCQ_CTRL, 32'h149, `SCQ_RESP_OKAY);
    hit(rnd48(), 3'h0, 3'h0, 1'b0, 1);
    // Condition one compares the low data byte only.
    axi_write(`SCQ_QUAL_BASE0, 32'h5a, `SCQ_RESP_OKAY);
    axi_write(`SCQ_QUAL_BASE0 + 8'h08, 32'hff, `SCQ_RESP_OKAY);
    axi_write(`SCQ_QUAL_BASE0 + 8'h0c, 32'h0, `SCQ_RESP_OKAY);
    axi_write(`SCQ_CTRL, 32'h118, `SCQ_RESP_OKAY);
    d = rnd48();
    hit({d[47:8], 8'h5a}, 3'h0, 3'h0, 1'b0, 1);
    hit({d[47:8], 8'ha5}, 3'h0, 3'h0, 1'b0, 0);
    // Condition two: all six qualifiers high and the external line required.
    axi_write(`SCQ_QUAL_BASE1 + 8'h08, 32'h0, `SCQ_RESP_OKAY);
    axi_write(`SCQ_QUAL_BASE1 + 8'h0c, 32'h0, `SCQ_RESP_OKAY);
    axi_write(`SCQ_QUAL_BASE1 + 8'h10, 32'h0001_3f3f, `SCQ_RESP_OKAY);
    axi_write(`SCQ_CTRL, 32'h138, `SCQ_RESP_OKAY);
    hit({d[47:8], 8'h00}, 3'h7, 3'h7, 1'b1, 1);
    hit({d[47:8], 8'h00}, 3'h7, 3'h7, 1'b0, 0);
    hit({d[47:8], 8'h00}, 3'h7, 3'h6, 1'b1, 0);
    hit({d[47:8], 8'h5a}, 3'h0, 3'h0, 1'b0, 1);
    axi_write(`SCQ_CTRL, 32'h108, `SCQ_RESP_OKAY);
    hit({d[47:8], 8'h00}, 3'h0, 3'h0, 1'b0, 1);
    // Multiphase: B latches on its own falling edge, after A has already stored.
    axi_write(`SCQ_CTRL, 32'h002, `SCQ_RESP_OKAY);
    exp_word.push_back({16'h1234, d[31:16], 16'h5678});
    u_probe.strobe(48'h1234_9abc_5678, 3'h0, 3'h0, 1'b0);
    trigger_in <= 1'b1;
    exp_word.push_back({16'h0f0f, 16'h9abc, 16'hf0f0});
    u_probe.strobe(48'h0f0f_1111_f0f0, 3'h0, 3'h0, 1'b0);
    axi_read(`SCQ_STATUS, 32'h0002_0003);
    axi_write(`SCQ_SHOW_MASK_LO, 32'hffff_0000, `SCQ_RESP_OKAY);
    axi_read(`SCQ_READ_DATA_LO, {d[31:16], 16'h0000});
    repeat (5) @(posedge core_clk);
    check(exp_word.size(), 0);
    summarize();
  end
endmodule // state_clock_qualifier_tb_top
`default_nettype wire
